// ==== rtl/mmc_mgmt_port.sv ====
// management port of a pluggable module: select, reset, interrupt, memory
`timescale 1ns/1ps

module mmc_mgmt_port #(
	parameter int INIT_CYCLES = mmc_pkg::INIT_CYCLES
) (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  nrst,
	// two-wire management bus
	input  wire mmc_pkg::mmc_twi_in_t  twiIn,
	output      mmc_pkg::mmc_twi_out_t twiOut,
	// control pins from the host
	input  wire logic                  module_select_n,
	input  wire logic                  module_reset_n,
	input  wire logic                  low_power_select,
	// status pins to the host
	output      logic                  interrupt_out_n,
	output      logic                  interruptOe,
	output      logic                  module_present_n,
	// module internals
	input  wire logic [7:0]            faultEvents,
	output      logic                  lowPowerEnable,
	output      logic                  settingsReset
);
	import mmc_pkg::*;

	// ----------------------------------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rstPipe;
	logic       rstN;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rstPipe <= 2'b00;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstN = rstPipe[1];

	logic [4:0] pinSync;
	logic       sclS;
	logic       sdaS;
	logic       selN;
	logic       rstPinN;
	logic       lpmS;

	// bus lines idle high and low power off, so no false edge after reset
	mmc_sync #(.W(5), .RST_VAL(5'h1e)) u_sync (
		.clk  (mclk),
		.rstN (rstN),
		.din  ({twiIn.scl, twiIn.sda, module_select_n, module_reset_n,
			low_power_select}),
		.dout (pinSync)
	);
	assign {sclS, sdaS, selN, rstPinN, lpmS} = pinSync;

	logic userReset;
	logic initBusy;
	logic initDone;

	mmc_reset_seq #(.INIT_CYCLES(INIT_CYCLES)) u_rseq (
		.clk       (mclk),
		.rstN      (rstN),
		.pinLow    (!rstPinN),
		.userReset (userReset),
		.initBusy  (initBusy),
		.initDone  (initDone)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		mmc_state_t                     st;
		logic [3:0]                     bitCnt;
		logic [7:0]                     shreg;
		logic [7:0]                     addr;
		logic                           rw;
		logic                           ptrPhase;
		logic                           sdaOe;
		logic                           sclPrev;
		logic                           sdaPrev;
		logic                           donePend;
		logic                           lowPower;
		logic [7:0]                     flags;
		logic [CTRL_BYTES-1:0][7:0]     ctrl;
	} mmc_port_t;

	mmc_port_t s;
	mmc_port_t next_s;

	// page 02 is user storage and keeps its content over a module reset
	logic [7:0] userMem [UPPER_BYTES];
	logic       memWe;
	logic [7:0] rdData;
	logic [5:0] ctrlIdx;
	logic [7:0] page;
	logic [7:0] mask;
	logic       sclRise;
	logic       sclFall;
	logic       startCond;
	logic       stopCond;
	logic       irq;

	assign sclRise   = sclS && !s.sclPrev;
	assign sclFall   = !sclS && s.sclPrev;
	assign startCond = sclS && s.sclPrev && s.sdaPrev && !sdaS;
	assign stopCond  = sclS && s.sclPrev && !s.sdaPrev && sdaS;
	assign ctrlIdx   = 6'(s.addr - CTRL_FIRST);
	assign page      = s.ctrl[PAGE_IDX];
	assign mask      = s.ctrl[MASK_IDX];

	// ----------------------------------------------------------------
	// memory read map
	// ----------------------------------------------------------------
	always_comb begin
		rdData = 8'h00;
		if (!s.addr[7]) begin
			if (s.addr == ADDR_ID) begin
				rdData = ID_CODE;
			end else if (s.addr == ADDR_STATUS) begin
				rdData = 8'(initBusy) << DNR_BIT;
			end else if (s.addr == ADDR_FLAGS) begin
				rdData = s.flags;
			end else if (s.addr >= CTRL_FIRST) begin
				rdData = s.ctrl[ctrlIdx];
			end
		end else if (page == PAGE_USER) begin
			rdData = userMem[s.addr[6:0]];
		end else if (page == PAGE_ID && s.addr == ADDR_ID_UP) begin
			rdData = ID_CODE;
		end
	end

	// ----------------------------------------------------------------
	// serial engine
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		memWe = 1'b0;
		next_s.sclPrev = sclS;
		next_s.sdaPrev = sdaS;
		next_s.lowPower = lpmS;
		next_s.flags = s.flags | faultEvents;
		if (initDone) begin
			next_s.donePend = 1'b1;
		end
		case (s.st)
			ST_DEVADDR: begin
				if (sclRise) begin
					next_s.shreg = {s.shreg[6:0], sdaS};
					next_s.bitCnt = s.bitCnt + 4'h1;
				end else if (sclFall && s.bitCnt == 4'h8) begin
					if (s.shreg[7:1] == DEV_ADDR) begin
						next_s.st = ST_ADDRACK;
						next_s.sdaOe = 1'b1;
						next_s.rw = s.shreg[0];
					end else begin
						next_s.st = ST_IDLE;
					end
				end
			end
			ST_ADDRACK, ST_RDACK: begin
				if (s.st == ST_RDACK && sclRise && sdaS) begin
					next_s.st = ST_IDLE;
				end else if (sclFall && (s.rw || s.st == ST_RDACK)) begin
					next_s.st = ST_RDBYTE;
					next_s.shreg = rdData;
					next_s.sdaOe = !rdData[7];
					next_s.bitCnt = 4'h0;
					// reading a byte clears what it reported; new events win
					if (s.addr == ADDR_STATUS && !initDone) begin
						next_s.donePend = 1'b0;
					end
					if (s.addr == ADDR_FLAGS) begin
						next_s.flags = faultEvents;
					end
				end else if (sclFall) begin
					next_s.st = ST_WRBYTE;
					next_s.sdaOe = 1'b0;
					next_s.bitCnt = 4'h0;
				end
			end
			ST_WRBYTE: begin
				if (sclRise) begin
					next_s.shreg = {s.shreg[6:0], sdaS};
					next_s.bitCnt = s.bitCnt + 4'h1;
				end else if (sclFall && s.bitCnt == 4'h8) begin
					next_s.st = ST_WRACK;
					next_s.sdaOe = 1'b1;
					if (s.ptrPhase) begin
						next_s.addr = s.shreg;
						next_s.ptrPhase = 1'b0;
					end else begin
						next_s.addr = s.addr + 8'h01;
						if (!s.addr[7] && s.addr >= CTRL_FIRST) begin
							next_s.ctrl[ctrlIdx] = s.shreg;
						end else if (s.addr[7] && page == PAGE_USER) begin
							memWe = 1'b1;
						end
					end
				end
			end
			ST_WRACK: begin
				if (sclFall) begin
					next_s.st = ST_WRBYTE;
					next_s.sdaOe = 1'b0;
					next_s.bitCnt = 4'h0;
				end
			end
			ST_RDBYTE: begin
				if (sclFall && s.bitCnt == 4'h7) begin
					next_s.st = ST_RDACK;
					next_s.sdaOe = 1'b0;
					next_s.addr = s.addr + 8'h01;
				end else if (sclFall) begin
					next_s.shreg = {s.shreg[6:0], 1'b0};
					next_s.sdaOe = !s.shreg[6];
					next_s.bitCnt = s.bitCnt + 4'h1;
				end
			end
			default: begin
				next_s.sdaOe = 1'b0;
			end
		endcase
		// a deselected module never drives the data line
		if (stopCond || selN) begin
			next_s.st = ST_IDLE;
			next_s.sdaOe = 1'b0;
		end else if (startCond) begin
			next_s.st = ST_DEVADDR;
			next_s.sdaOe = 1'b0;
			next_s.bitCnt = 4'h0;
			next_s.ptrPhase = 1'b1;
		end
		if (userReset) begin
			next_s.st = ST_IDLE;
			next_s.sdaOe = 1'b0;
			next_s.ctrl = {CTRL_BYTES{CTRL_RESET}};
			memWe = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			s <= '{st: ST_IDLE, bitCnt: 4'h0, shreg: 8'h00, addr: 8'h00,
				rw: 1'b0, ptrPhase: 1'b0, sdaOe: 1'b0, sclPrev: 1'b1,
				sdaPrev: 1'b1, donePend: 1'b0, lowPower: 1'b0,
				flags: 8'h00, ctrl: {CTRL_BYTES{CTRL_RESET}}};
		end else begin
			s <= next_s;
		end
	end

	always_ff @(posedge mclk) begin
		if (memWe) begin
			userMem[s.addr[6:0]] <= s.shreg;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// faults stay quiet while data is not ready, so completion is unambiguous
	assign irq = s.donePend || (!initBusy && |(s.flags & ~mask));
	assign interrupt_out_n = 1'b0;
	assign interruptOe     = irq;
	assign twiOut          = '{sdaOut: 1'b0, sdaOe: s.sdaOe};
	assign module_present_n = 1'b0;
	assign lowPowerEnable  = s.lowPower;
	assign settingsReset   = userReset;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstN);

	sequence addrByteDone;
		s.st == ST_DEVADDR && sclFall && s.bitCnt == 4'h8;
	endsequence

	sequence completionSeen;
		initDone ##1 (interruptOe && !initBusy);
	endsequence

	deselect_quiet_a: assert property (
		selN |=> (s.st == ST_IDLE && !twiOut.sdaOe))
		else $error("deselected module left the bus active");

	addr_ack_a: assert property (
		(addrByteDone and (s.shreg[7:1] == DEV_ADDR) and !selN)
		|=> (twiOut.sdaOe && s.st == ST_ADDRACK))
		else $error("own address not acknowledged");

	foreign_addr_a: assert property (
		(addrByteDone and (s.shreg[7:1] != DEV_ADDR))
		|=> (s.st == ST_IDLE && !twiOut.sdaOe))
		else $error("foreign address acknowledged");

	settings_default_a: assert property (
		userReset |=> (s.ctrl == {CTRL_BYTES{CTRL_RESET}}))
		else $error("settings not restored by module reset");

	init_start_a: assert property (
		userReset |-> (initBusy ##1 initBusy[*3]))
		else $error("completion interval did not start");

	dnr_busy_a: assert property (
		(s.st == ST_ADDRACK && s.rw && sclFall && initBusy
		&& s.addr == ADDR_STATUS) |=> s.shreg[DNR_BIT])
		else $error("data-not-ready clear while busy");

	completion_int_a: assert property (
		initDone |-> completionSeen)
		else $error("completion interrupt missing");

	int_hold_a: assert property (
		(s.donePend && !(s.st == ST_RDACK || s.st == ST_ADDRACK))
		|=> interruptOe)
		else $error("pending completion interrupt dropped");

	low_power_a: assert property (
		$changed(lpmS) |=> (lowPowerEnable == $past(lpmS)))
		else $error("low-power state does not follow its pin");

	fault_int_a: assert property (
		(!initBusy && |(s.flags & ~mask)) |-> interruptOe)
		else $error("unmasked fault not signalled");
endmodule

// ==== rtl/mmc_reset_seq.sv ====
// reset pin pulse qualifier and reset completion timer
`timescale 1ns/1ps
module mmc_reset_seq #(
	parameter int INIT_CYCLES = mmc_pkg::INIT_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rstN,
	// synchronised reset pin, high while the pin is low
	input  wire logic pinLow,
	// sequence outputs
	output      logic userReset,
	output      logic initBusy,
	output      logic initDone
);
	import mmc_pkg::*;

	typedef struct packed {
		logic [15:0] lowCnt;
		logic [31:0] initCnt;
		logic        prevLow;
		logic        busy;
		logic        rstPulse;
		logic        done;
	} mmc_rseq_t;

	mmc_rseq_t s;
	mmc_rseq_t next_s;

	always_comb begin
		next_s = s;
		next_s.prevLow = pinLow;
		next_s.rstPulse = 1'b0;
		next_s.done = 1'b0;
		if (pinLow && s.lowCnt != 16'(RESET_MIN_CYCLES)) begin
			next_s.lowCnt = s.lowCnt + 16'h0001;
		end
		// timer starts on the release edge of a long enough pulse
		if (s.prevLow && !pinLow) begin
			next_s.lowCnt = 16'h0000;
			if (s.lowCnt == 16'(RESET_MIN_CYCLES)) begin
				next_s.rstPulse = 1'b1;
				next_s.busy = 1'b1;
				next_s.initCnt = 32'h0000_0000;
			end
		end else if (s.busy) begin
			if (s.initCnt == 32'(INIT_CYCLES - 1)) begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end else begin
				next_s.initCnt = s.initCnt + 32'h0000_0001;
			end
		end
	end

	// power-up starts busy so completion is posted without a pin pulse
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			s <= '{lowCnt: 16'h0000, initCnt: 32'h0000_0000,
				prevLow: 1'b0, busy: 1'b1, rstPulse: 1'b0,
				done: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign userReset = s.rstPulse;
	assign initBusy = s.busy;
	assign initDone = s.done;
endmodule

// ==== rtl/mmc_sync.sv ====
// two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
module mmc_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstN,
	// levels
	input  wire logic [W-1:0] din,
	output      logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} mmc_sync_t;

	mmc_sync_t s;
	mmc_sync_t next_s;

	always_comb begin
		next_s.s1 = din;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			s <= {RST_VAL, RST_VAL};
		end else begin
			s <= next_s;
		end
	end

	assign dout = s.s2;
endmodule

// ==== shared/mmc_pkg.sv ====
// constants, states and pin bundles of the module management port
package mmc_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ           = 50_000_000;
	localparam int T_RESET_MIN_NS   = 10_000;
	localparam int RESET_MIN_CYCLES =
		(T_RESET_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int T_INIT_MS        = 2000;
	localparam int INIT_CYCLES      = T_INIT_MS * (CLK_HZ / 1000);

	// ----------------------------------------------------------------
	// bus address and memory layout
	// ----------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR     = 7'h50;
	localparam logic [7:0] ADDR_ID      = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h02;
	localparam logic [7:0] ADDR_FLAGS   = 8'h03;
	localparam logic [7:0] CTRL_FIRST   = 8'h56;
	localparam logic [7:0] ADDR_MASK    = 8'h64;
	localparam logic [7:0] ADDR_PAGE    = 8'h7f;
	localparam logic [7:0] ADDR_ID_UP   = 8'h80;
	localparam logic [7:0] PAGE_ID      = 8'h00;
	localparam logic [7:0] PAGE_USER    = 8'h02;
	localparam int         CTRL_BYTES   = 42;
	localparam int         MASK_IDX     = 14;
	localparam int         PAGE_IDX     = 41;
	localparam int         DNR_BIT      = 0;
	localparam int         UPPER_BYTES  = 128;
	// identifier value is arbitrary
	localparam logic [7:0] ID_CODE      = 8'h5a;
	localparam logic [7:0] CTRL_RESET   = 8'h00;

	// ----------------------------------------------------------------
	// serial engine states and pin bundles
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_DEVADDR = 3'b001,
		ST_ADDRACK = 3'b010,
		ST_WRBYTE  = 3'b011,
		ST_WRACK   = 3'b100,
		ST_RDBYTE  = 3'b101,
		ST_RDACK   = 3'b110
	} mmc_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} mmc_twi_in_t;

	typedef struct packed {
		logic sdaOut;
		logic sdaOe;
	} mmc_twi_out_t;

endpackage

// ==== verification/mmc_host_model.sv ====
// host controller model that drives the two-wire management bus
`timescale 1ns/1ps
module mmc_host_model (
	// clock
	input  wire logic mclk,
	// open-drain bus: level on the wire, clock out, data pull-down
	input  wire logic sdaLine,
	output      logic scl,
	output      logic sdaLow
);
	import mmc_pkg::*;

	// bus idles: clock driven high, data released high through the pull-up
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// ----------------------------------------------------------------
	// bit level, 160 ns per bit
	// ----------------------------------------------------------------
	// data moves two cycles into the low phase, clear of both edges
	task automatic bitIo(input logic b, output logic seen);
		sdaLow <= !b;
		tick(2);
		scl <= 1'b1;
		tick(4);
		seen = sdaLine;
		scl <= 1'b0;
		tick(2);
	endtask

	task automatic start();
		sdaLow <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sdaLow <= 1'b1;
		tick(4);
		scl <= 1'b0;
		tick(2);
	endtask

	// clock is left high afterwards, so it stands still between frames
	task automatic stop();
		sdaLow <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sdaLow <= 1'b0;
		tick(4);
	endtask

	// ----------------------------------------------------------------
	// byte level
	// ----------------------------------------------------------------
	task automatic byteOut(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitIo(b[i], s);
		end
		bitIo(1'b1, s);
		ack = !s;
	endtask

	task automatic byteIn(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitIo(1'b1, b[i]);
		end
		bitIo(last, s);
	endtask

	// pointer then one data byte; ack is high only if all three acked
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [7:0] dat, output logic ack);
		logic a;
		logic b;
		logic c;
		start();
		byteOut({dev, 1'b0}, a);
		byteOut(ptr, b);
		byteOut(dat, c);
		stop();
		ack = a & b & c;
	endtask

	// pointer write, repeated start, one byte ended by a nack
	task automatic rd(input logic [7:0] ptr, output logic [7:0] dat);
		logic a;
		start();
		byteOut({DEV_ADDR, 1'b0}, a);
		byteOut(ptr, a);
		start();
		byteOut({DEV_ADDR, 1'b1}, a);
		byteIn(1'b1, dat);
		stop();
	endtask
endmodule

// ==== verification/module_mgmt_control_port_bench.sv ====
// self-checking bench of the module management port
`timescale 1ns/1ps
module module_mgmt_control_port_bench;
	import mmc_pkg::*;

	// short completion interval keeps the run brief
	localparam int INIT = 2000;

	logic         mclk;
	logic         nrst;
	logic         module_select_n;
	logic         module_reset_n;
	logic         low_power_select;
	logic [7:0]   faultEvents;
	logic         scl;
	logic         sdaLow;
	logic         sdaLine;
	mmc_twi_in_t  twiIn;
	mmc_twi_out_t twiOut;
	logic         interrupt_out_n;
	logic         interruptOe;
	logic         module_present_n;
	logic         lowPowerEnable;
	logic         settingsReset;
	int           failures;
	int           cmpCount;
	int           cyc = 0;

	// pull-up: the wire is low only while some party pulls it
	assign sdaLine = !(twiOut.sdaOe || sdaLow);
	assign twiIn = {scl, sdaLine};

	mmc_mgmt_port #(.INIT_CYCLES(INIT)) mmc_mgmt_port_i (
		.mclk(mclk), .nrst(nrst), .twiIn(twiIn), .twiOut(twiOut),
		.module_select_n(module_select_n),
		.module_reset_n(module_reset_n),
		.low_power_select(low_power_select),
		.interrupt_out_n(interrupt_out_n), .interruptOe(interruptOe),
		.module_present_n(module_present_n), .faultEvents(faultEvents),
		.lowPowerEnable(lowPowerEnable), .settingsReset(settingsReset)
	);

	mmc_host_model mmc_host_model_i (
		.mclk(mclk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow)
	);

	always #10 mclk = ~mclk;

	always @(posedge mclk) cyc <= cyc + 1;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		if (failures == 0 && cmpCount > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic rdChk(input string what, input logic [7:0] ptr,
		input logic [7:0] mask, input logic [7:0] exp);
		logic [7:0] d;
		mmc_host_model_i.rd(ptr, d);
		chk(what, d & mask, exp);
	endtask

	// bounded wait for the interrupt; running out ends the run
	task automatic waitInt(input int n);
		int k;
		k = 0;
		while (interruptOe !== 1'b1 && k < n) begin
			@(posedge mclk);
			k++;
		end
		if (interruptOe !== 1'b1) begin
			chk("interrupt wait", 8'h00, 8'h01);
			test_done();
		end
	endtask

	// counts the cycles in which the settings reset pulse is high
	task automatic cntPulse(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge mclk);
			c += (settingsReset === 1'b1);
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic sPowerUp();
		tick(6);
		chk("present", {7'h0, module_present_n}, 8'h00);
		chk("sda level", {7'h0, twiOut.sdaOut}, 8'h00);
		rdChk("not ready", ADDR_STATUS, 8'h01, 8'h01);
		chk("busy irq", {7'h0, interruptOe}, 8'h00);
		rdChk("id", ADDR_ID, 8'hff, ID_CODE);
		waitInt(3 * INIT);
		rdChk("ready", ADDR_STATUS, 8'h01, 8'h00);
		chk("irq cleared", {7'h0, interruptOe}, 8'h00);
	endtask

	task automatic sAddress();
		logic ack;
		mmc_host_model_i.wr(7'h51, CTRL_FIRST, 8'h3c, ack);
		chk("foreign ack", {7'h0, ack}, 8'h00);
		module_select_n <= 1'b1;
		tick(4);
		mmc_host_model_i.wr(DEV_ADDR, CTRL_FIRST, 8'h3c, ack);
		chk("deselected ack", {7'h0, ack}, 8'h00);
		module_select_n <= 1'b0;
		tick(4);
		rdChk("unwritten", CTRL_FIRST, 8'hff, CTRL_RESET);
		mmc_host_model_i.wr(DEV_ADDR, CTRL_FIRST, 8'h55, ack);
		chk("selected ack", {7'h0, ack}, 8'h01);
		rdChk("setting", CTRL_FIRST, 8'hff, 8'h55);
	endtask

	task automatic sMemory();
		logic ack;
		mmc_host_model_i.wr(DEV_ADDR, ADDR_PAGE, PAGE_USER, ack);
		mmc_host_model_i.wr(DEV_ADDR, ADDR_ID_UP, 8'ha7, ack);
		rdChk("user page", ADDR_ID_UP, 8'hff, 8'ha7);
		rdChk("lower fixed", ADDR_ID, 8'hff, ID_CODE);
		mmc_host_model_i.wr(DEV_ADDR, ADDR_PAGE, PAGE_ID, ack);
		rdChk("id page", ADDR_ID_UP, 8'hff, ID_CODE);
		mmc_host_model_i.wr(DEV_ADDR, ADDR_ID, 8'hff, ack);
		rdChk("read-only id", ADDR_ID, 8'hff, ID_CODE);
	endtask

	task automatic sFault();
		logic ack;
		faultEvents <= 8'h04;
		tick(1);
		faultEvents <= 8'h00;
		waitInt(10);
		chk("int level", {7'h0, interrupt_out_n}, 8'h00);
		rdChk("flags", ADDR_FLAGS, 8'hff, 8'h04);
		chk("fault irq off", {7'h0, interruptOe}, 8'h00);
		rdChk("flags cleared", ADDR_FLAGS, 8'hff, 8'h00);
		// a masked fault is latched but stays off the interrupt pin
		mmc_host_model_i.wr(DEV_ADDR, ADDR_MASK, 8'h04, ack);
		faultEvents <= 8'h04;
		tick(1);
		faultEvents <= 8'h00;
		tick(4);
		chk("masked irq", {7'h0, interruptOe}, 8'h00);
		rdChk("masked flag", ADDR_FLAGS, 8'hff, 8'h04);
		mmc_host_model_i.wr(DEV_ADDR, ADDR_MASK, 8'h00, ack);
		chk("mask ack", {7'h0, ack}, 8'h01);
	endtask

	task automatic sLowPower();
		low_power_select <= 1'b1;
		tick(6);
		chk("low power on", {7'h0, lowPowerEnable}, 8'h01);
		low_power_select <= 1'b0;
		tick(6);
		chk("low power off", {7'h0, lowPowerEnable}, 8'h00);
	endtask

	task automatic sModReset();
		int c;
		int t0;
		int dt;
		module_reset_n <= 1'b0;
		cntPulse(100, c);
		module_reset_n <= 1'b1;
		cntPulse(20, c);
		chk("short pulse", c[7:0], 8'h00);
		rdChk("short kept", CTRL_FIRST, 8'hff, 8'h55);
		module_reset_n <= 1'b0;
		cntPulse(520, c);
		chk("pulse while low", c[7:0], 8'h00);
		module_reset_n <= 1'b1;
		t0 = cyc;
		cntPulse(10, c);
		chk("pulse after rise", c[7:0], 8'h01);
		rdChk("reset busy", ADDR_STATUS, 8'h01, 8'h01);
		waitInt(3 * INIT);
		dt = cyc - t0;
		chk("interval", 8'(dt >= INIT && dt <= INIT + 16), 8'h01);
		rdChk("reset ready", ADDR_STATUS, 8'h01, 8'h00);
		rdChk("defaults", CTRL_FIRST, 8'hff, CTRL_RESET);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		module_select_n = 1'b0;
		module_reset_n = 1'b1;
		low_power_select = 1'b0;
		faultEvents = 8'h00;
		failures = 0;
		cmpCount = 0;
		tick(16);
		nrst <= 1'b1;
		sPowerUp();
		sAddress();
		sMemory();
		sFault();
		sLowPower();
		sModReset();
		test_done();
	end
endmodule
